//--- hdl/nem_pkg.sv
package nem_pkg;

  // ****************************************************************
  // Control word fields
  // ****************************************************************
  localparam int          CW_WIDTH       = 16;
  localparam int          CW_INVALID_POS = 0;
  localparam int          CW_DENORM_POS  = 1;
  localparam int          CW_ZDIV_POS    = 2;
  localparam int          CW_OVER_POS    = 3;
  localparam int          CW_UNDER_POS   = 4;
  localparam int          CW_PREC_POS    = 5;
  localparam int          CW_INTMASK_POS = 7;
  localparam logic [15:0] CW_RESET       = 16'h03FF;

  // ****************************************************************
  // Status byte and tag word
  // ****************************************************************
  localparam int          EXC_COUNT      = 6;
  localparam int          SW_WIDTH       = 8;
  localparam int          SW_IRQ_POS     = 7;
  localparam int          TAG_REGS       = 8;
  localparam int          TAG_WIDTH      = 2;
  localparam int          TW_WIDTH       = 16;
  localparam logic [15:0] TW_RESET       = 16'hFFFF;

  typedef enum logic [1:0] {
    NEM_TAG_VALID   = 2'h0,
    NEM_TAG_ZERO    = 2'h1,
    NEM_TAG_SPECIAL = 2'h2,
    NEM_TAG_EMPTY   = 2'h3
  } nem_tag_t;

  // Exception flags in status bit order, bit 5 down to bit 0
  typedef struct packed {
    logic prec;
    logic under;
    logic over;
    logic zdiv;
    logic denorm;
    logic invalid;
  } nem_exc_t;

  // Outcome of one numeric operation as seen by the execution unit
  typedef struct packed {
    logic is_divide;
    logic divisor_zero;
    logic dividend_finite_nonzero;
    logic invalid;
    logic denorm_operand;
    logic result_too_large;
    logic result_too_small;
    logic result_nonzero;
    logic result_inexact;
  } nem_op_t;

  // Default responses chosen for masked exceptions
  typedef struct packed {
    logic give_infinity;
    logic denormalize;
    logic give_indefinite;
    logic proceed;
  } nem_resp_t;

  typedef enum logic [1:0] {
    NEM_RUN     = 2'b01,
    NEM_SUSPEND = 2'b10
  } nem_state_t;

endpackage

//--- hdl/nem_exception_unit.sv
`timescale 1ns/1ns
`default_nettype none

// Function
// - Two-bit tag per stack register, eight kept
// - Control word loaded from memory word on command
// - Per-class mask bit; 1 selects default response
// - Global interrupt mask 1 blocks host interrupt
// - Zero divide flagged; masked returns infinity
// - Underflow flagged; masked denormalizes fraction right
// - Denormal operand flagged; masked processing continues
// - Inexact flagged; masked continues
// - Status bit 7 reflects any unmasked flag
// - Detected exceptions set status bits 5 to 0
// - Unmasked exception, interrupts off: suspend until cleared
// - Overflow flagged; masked returns infinity
module nem_exception_unit
  import nem_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  reset,
  input  wire logic                  ctrl_load,
  input  wire logic [CW_WIDTH-1:0]   ctrl_data,
  input  wire logic                  tag_load,
  input  wire logic [TW_WIDTH-1:0]   tag_data,
  input  wire logic                  tag_set,
  input  wire logic [2:0]            tag_index,
  input  wire nem_tag_t              tag_value,
  input  wire logic                  op_valid,
  input  wire nem_op_t               op_info,
  input  wire logic                  flag_clear,
  input  wire logic [EXC_COUNT-1:0]  flag_clear_mask,
  output var  logic [CW_WIDTH-1:0]   control_word_q,
  output var  logic [TW_WIDTH-1:0]   tag_word_q,
  output var  logic [SW_WIDTH-1:0]   status_byte_q,
  output var  logic                  interrupt_q,
  output var  logic                  suspended_q,
  output var  logic                  op_done_q,
  output var  nem_resp_t             response_q
);

  // ****************************************************************
  // Next-state signals
  // ****************************************************************
  logic [CW_WIDTH-1:0]  control_word_d;
  logic [TW_WIDTH-1:0]  tag_word_d;
  nem_exc_t             flags_q;
  nem_exc_t             flags_d;
  nem_exc_t             detected;
  nem_exc_t             masks;
  nem_exc_t             masks_d;
  logic                 irq_d;
  logic                 int_masked_d;
  logic                 op_take;
  nem_state_t           state_q;
  nem_state_t           state_d;
  nem_resp_t            response_d;
  logic                 op_done_d;

  assign masks = nem_exc_t'({control_word_q[CW_PREC_POS],   control_word_q[CW_UNDER_POS],
                             control_word_q[CW_OVER_POS],   control_word_q[CW_ZDIV_POS],
                             control_word_q[CW_DENORM_POS], control_word_q[CW_INVALID_POS]});

  // ****************************************************************
  // Control word
  // ****************************************************************
  always_comb begin
    control_word_d = control_word_q;
    if (ctrl_load) begin
      control_word_d = ctrl_data;
    end
  end

  assign masks_d = nem_exc_t'({control_word_d[CW_PREC_POS],   control_word_d[CW_UNDER_POS],
                               control_word_d[CW_OVER_POS],   control_word_d[CW_ZDIV_POS],
                               control_word_d[CW_DENORM_POS], control_word_d[CW_INVALID_POS]});
  assign int_masked_d = control_word_d[CW_INTMASK_POS];

  // ****************************************************************
  // Tag word
  // ****************************************************************
  logic [TW_WIDTH-1:0] tag_field_d;

  genvar gi;
  generate
    for (gi = 0; gi < TAG_REGS; gi++) begin : g_tag
      always_comb begin
        tag_field_d[gi*TAG_WIDTH +: TAG_WIDTH] = tag_word_q[gi*TAG_WIDTH +: TAG_WIDTH];
        if (tag_load) begin
          tag_field_d[gi*TAG_WIDTH +: TAG_WIDTH] = tag_data[gi*TAG_WIDTH +: TAG_WIDTH];
        end
        if (tag_set && (tag_index == 3'(gi))) begin
          tag_field_d[gi*TAG_WIDTH +: TAG_WIDTH] = tag_value;
        end
      end
    end
  endgenerate

  assign tag_word_d = tag_field_d;

  // ****************************************************************
  // Exception detection
  // ****************************************************************
  assign op_take = op_valid && (state_q == NEM_RUN);

  always_comb begin
    detected         = '0;
    detected.invalid = op_take && op_info.invalid;
    detected.zdiv    = op_take && op_info.is_divide && op_info.divisor_zero
                       && op_info.dividend_finite_nonzero;
    detected.over    = op_take && op_info.result_too_large;
    detected.under   = op_take && op_info.result_too_small
                       && op_info.result_nonzero;
    detected.denorm  = op_take && op_info.denorm_operand;
    detected.prec    = op_take && op_info.result_inexact;
  end

  // Set wins over a clear in the same cycle
  always_comb begin
    flags_d = flags_q;
    if (flag_clear) begin
      flags_d = nem_exc_t'(flags_q & ~flag_clear_mask);
    end
    flags_d = nem_exc_t'(flags_d | detected);
  end

  assign irq_d = |(flags_d & ~masks_d);

  // ****************************************************************
  // Default responses
  // ****************************************************************
  always_comb begin
    response_d                 = '0;
    op_done_d                  = op_take;
    response_d.give_infinity   = (detected.zdiv && masks.zdiv)
                                 || (detected.over && masks.over);
    response_d.denormalize     = detected.under && masks.under;
    response_d.give_indefinite = detected.invalid && masks.invalid;
    response_d.proceed         = op_take && ~|(detected & ~masks);
  end

  // ****************************************************************
  // Run and suspend
  // ****************************************************************
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      NEM_RUN: begin
        if (irq_d && int_masked_d) begin
          state_d = NEM_SUSPEND;
        end
      end
      NEM_SUSPEND: begin
        if (!(irq_d && int_masked_d)) begin
          state_d = NEM_RUN;
        end
      end
      default: begin
        state_d = NEM_RUN;
      end
    endcase
  end

  // ****************************************************************
  // Status byte, interrupt and suspend levels
  // ****************************************************************
  logic [SW_WIDTH-1:0]  status_byte_d;
  logic                 interrupt_d;
  logic                 suspended_d;

  // Levels follow the new control word in the same cycle
  always_comb begin
    status_byte_d                = '0;
    status_byte_d[SW_IRQ_POS]    = irq_d;
    status_byte_d[EXC_COUNT-1:0] = flags_d;
    interrupt_d                  = irq_d && !int_masked_d;
    suspended_d                  = (state_d == NEM_SUSPEND);
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (reset) begin
      control_word_q <= CW_RESET;
      tag_word_q     <= TW_RESET;
    end else begin
      control_word_q <= control_word_d;
      tag_word_q     <= tag_word_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      flags_q       <= '0;
      status_byte_q <= '0;
      interrupt_q   <= 1'b0;
    end else begin
      flags_q       <= flags_d;
      status_byte_q <= status_byte_d;
      interrupt_q   <= interrupt_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_q     <= NEM_RUN;
      suspended_q <= 1'b0;
    end else begin
      state_q     <= state_d;
      suspended_q <= suspended_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      response_q <= '0;
      op_done_q  <= 1'b0;
    end else begin
      response_q <= response_d;
      op_done_q  <= op_done_d;
    end
  end

endmodule // nem_exception_unit

`default_nettype wire

//--- test/nem_exception_unit_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module nem_exception_unit_assertions
  import nem_pkg::*;
(
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic        ctrl_load,
  input wire logic [15:0] ctrl_data,
  input wire logic        op_valid,
  input wire nem_op_t     op_info,
  input wire logic        flag_clear,
  input wire logic [15:0] control_word_q,
  input wire logic [7:0]  status_byte_q,
  input wire logic        interrupt_q,
  input wire logic        suspended_q,
  input wire logic        op_done_q,
  input wire nem_resp_t   response_q
);
  // ****
  // Checks
  // ****
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  logic acc;
  assign acc = op_valid && !suspended_q && !ctrl_load;
  AST_CW_LOAD: assert property (ctrl_load |=> control_word_q == $past(ctrl_data))
    else $error("control word load wrong");
  AST_IRQ_BIT: assert property (status_byte_q[7] == |(status_byte_q[5:0] & ~control_word_q[5:0]))
    else $error("request bit wrong");
  AST_INT_OUT: assert property (interrupt_q == (status_byte_q[7] && !control_word_q[7]))
    else $error("interrupt level wrong");
  AST_SUSP_LVL: assert property (suspended_q == (status_byte_q[7] && control_word_q[7]))
    else $error("suspend level wrong");
  AST_SUSP_REFUSE: assert property (suspended_q |=> !op_done_q)
    else $error("op taken while suspended");
  AST_ZDIV: assert property (acc && op_info.is_divide && op_info.divisor_zero
    && op_info.dividend_finite_nonzero |=> status_byte_q[2] && op_done_q)
    else $error("zero divide not flagged");
  AST_OVER_INF: assert property (acc && op_info.result_too_large && control_word_q[3]
    |=> response_q.give_infinity)
    else $error("overflow default wrong");
  AST_UNDER: assert property (acc && op_info.result_too_small && op_info.result_nonzero
    && control_word_q[4] |=> response_q.denormalize && status_byte_q[4])
    else $error("underflow default wrong");
  AST_STICKY: assert property (!flag_clear |=>
    (status_byte_q[5:0] & $past(status_byte_q[5:0])) == $past(status_byte_q[5:0]))
    else $error("flag lost without clear");
  cover property (acc && op_info.is_divide);
  cover property ($rose(suspended_q));
  cover property (flag_clear && suspended_q);
endmodule // nem_exception_unit_assertions
`default_nettype wire

//--- test/nem_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module nem_host_model
  import nem_pkg::*;
(
  input  wire logic        mclk,
  output var  logic        ctrl_load,
  output var  logic [15:0] ctrl_data,
  output var  logic        tag_load,
  output var  logic [15:0] tag_data,
  output var  logic        tag_set,
  output var  logic [2:0]  tag_index,
  output var  nem_tag_t    tag_value,
  output var  logic        op_valid,
  output var  nem_op_t     op_info,
  output var  logic        flag_clear,
  output var  logic [5:0]  flag_clear_mask
);
  initial begin
    {ctrl_load, tag_load, tag_set, op_valid, flag_clear} = '0;
    {ctrl_data, tag_data, tag_index, op_info, flag_clear_mask} = '0;
    tag_value = NEM_TAG_EMPTY;
  end
  // One strobe cycle; released data lines no longer hold their value
  // Each request first lets one idle edge pass, so no line is set twice at once
  task automatic pulse(input logic [4:0] s);
    {ctrl_load, tag_load, tag_set, op_valid, flag_clear} = s;
    @(posedge mclk);
    #5;
    {ctrl_load, tag_load, tag_set, op_valid, flag_clear} = '0;
    ctrl_data = ~ctrl_data;
    tag_data = ~tag_data;
    op_info = ~op_info;
  endtask
  task automatic wr_ctrl(input logic [15:0] d);
    @(posedge mclk);
    #5;
    ctrl_data = d;
    pulse(5'h10);
  endtask
  task automatic wr_tags(input logic [15:0] d);
    @(posedge mclk);
    #5;
    tag_data = d;
    pulse(5'h08);
  endtask
  task automatic set_tag(input logic [2:0] i, input nem_tag_t v);
    @(posedge mclk);
    #5;
    tag_index = i;
    tag_value = v;
    pulse(5'h04);
  endtask
  task automatic run_op(input nem_op_t o);
    @(posedge mclk);
    #5;
    op_info = o;
    pulse(5'h02);
  endtask
  task automatic clr(input logic [5:0] m);
    @(posedge mclk);
    #5;
    flag_clear_mask = m;
    pulse(5'h01);
  endtask
endmodule // nem_host_model
`default_nettype wire

//--- test/test_nem_exception_unit.sv
`timescale 1ns/1ns
`default_nettype none
module test_nem_exception_unit import nem_pkg::*;;
  logic mclk, reset, ctrl_load, tag_load, tag_set, op_valid, flag_clear;
  logic interrupt_q, suspended_q, op_done_q;
  logic [15:0] ctrl_data, tag_data, control_word_q, tag_word_q;
  logic [7:0] status_byte_q;
  logic [5:0] flag_clear_mask;
  logic [2:0] tag_index;
  nem_tag_t tag_value;
  nem_op_t op_info;
  nem_resp_t response_q;
  int bad_count, check_count;
  logic [8:0] ops [7] = '{9'h1C0, 9'h008, 9'h002, 9'h006, 9'h010, 9'h001, 9'h020};
  logic [7:0] sts [7] = '{8'h04, 8'h0C, 8'h0C, 8'h1C, 8'h1E, 8'h3E, 8'h3F};
  logic [3:0] rsp [7] = '{4'h9, 4'h9, 4'h1, 4'h5, 4'h1, 4'h1, 4'h3};
  nem_exception_unit u_nem_exception_unit (
    .mclk            (mclk),
    .reset           (reset),
    .ctrl_load       (ctrl_load),
    .ctrl_data       (ctrl_data),
    .tag_load        (tag_load),
    .tag_data        (tag_data),
    .tag_set         (tag_set),
    .tag_index       (tag_index),
    .tag_value       (tag_value),
    .op_valid        (op_valid),
    .op_info         (op_info),
    .flag_clear      (flag_clear),
    .flag_clear_mask (flag_clear_mask),
    .control_word_q  (control_word_q),
    .tag_word_q      (tag_word_q),
    .status_byte_q   (status_byte_q),
    .interrupt_q     (interrupt_q),
    .suspended_q     (suspended_q),
    .op_done_q       (op_done_q),
    .response_q      (response_q)
  );
  nem_host_model u_nem_host_model (
    .mclk            (mclk),
    .ctrl_load       (ctrl_load),
    .ctrl_data       (ctrl_data),
    .tag_load        (tag_load),
    .tag_data        (tag_data),
    .tag_set         (tag_set),
    .tag_index       (tag_index),
    .tag_value       (tag_value),
    .op_valid        (op_valid),
    .op_info         (op_info),
    .flag_clear      (flag_clear),
    .flag_clear_mask (flag_clear_mask)
  );
  initial begin
    mclk = 0;
    forever #25 mclk = ~mclk;
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic close_out;
    if (bad_count == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #200000;
    bad_count++;
    close_out;
  end
  // ****
  // Sequence
  // ****
  initial begin
    reset = 1;
    repeat (12) @(posedge mclk);
    #5 reset = 0;
    chk("ctrl", 16'h03FF, control_word_q);
    chk("tags", 16'hFFFF, tag_word_q);
    u_nem_host_model.wr_tags(16'h1B4E);
    chk("tags", 16'h1B4E, tag_word_q);
    for (int i = 0; i < 4; i++) u_nem_host_model.set_tag(3'(i), nem_tag_t'(i));
    chk("tags", 16'h1BE4, tag_word_q);
    for (int i = 0; i < 7; i++) begin
      u_nem_host_model.run_op(ops[i]);
      chk("done", 16'h0001, {15'h0, op_done_q});
      chk("resp", {12'h0, rsp[i]}, {12'h0, response_q});
      chk("status", {8'h0, sts[i]}, {8'h0, status_byte_q});
    end
    chk("irq", 16'h0000, {15'h0, interrupt_q});
    u_nem_host_model.clr(6'h3F);
    chk("status", 16'h0000, {8'h0, status_byte_q});
    u_nem_host_model.wr_ctrl(16'h037B);
    chk("ctrl", 16'h037B, control_word_q);
    u_nem_host_model.run_op(9'h1C0);
    chk("resp", 16'h0000, {12'h0, response_q});
    chk("status", 16'h0084, {8'h0, status_byte_q});
    chk("irq", 16'h0001, {15'h0, interrupt_q});
    u_nem_host_model.wr_ctrl(16'h03FB);
    chk("irq", 16'h0000, {15'h0, interrupt_q});
    chk("susp", 16'h0001, {15'h0, suspended_q});
    u_nem_host_model.run_op(9'h002);
    chk("done", 16'h0000, {15'h0, op_done_q});
    u_nem_host_model.clr(6'h04);
    chk("susp", 16'h0000, {15'h0, suspended_q});
    close_out;
  end
endmodule // test_nem_exception_unit
bind nem_exception_unit nem_exception_unit_assertions u_nem_exception_unit_assertions (
  .mclk           (mclk),
  .reset          (reset),
  .ctrl_load      (ctrl_load),
  .ctrl_data      (ctrl_data),
  .op_valid       (op_valid),
  .op_info        (op_info),
  .flag_clear     (flag_clear),
  .control_word_q (control_word_q),
  .status_byte_q  (status_byte_q),
  .interrupt_q    (interrupt_q),
  .suspended_q    (suspended_q),
  .op_done_q      (op_done_q),
  .response_q     (response_q)
);
`default_nettype wire
